// [rtl/cbrs_consts.svh]
// constants of the configuration backup and restore sequencer
// Operation
// R1 - The controller starts an upload or download with a request strobe that rests low and is high at least one cycle.
// R2 - An operation that does not finish in one cycle raises busy and keeps it high until it finishes.
// R3 - The result code is valid from the fall of busy until the next request strobe.
// R4 - Storage uses at most four consecutive storage blocks starting at the first storage block number.
// R5 - The storage block size lies in the allowed range and bounds the configuration bytes that fit.
// R6 - Upload with a missing or wrongly sized first block makes a fresh upload that overwrites old data.
// R7 - Upload with a valid block compares module and stored CRC and ends with result 0 when they match.
// R8 - Upload with differing CRCs copies configuration sub-indices 1 to 127 into storage, spilling into more blocks.
// R9 - Any upload error clears the stored CRC to zero so the next call uploads in full; the code leaves it unchanged on not-master and bad-size refusals.
// R10 - Download compares the CRCs and stops with an error when the first block is missing or wrongly sized.
// R11 - Download with matching CRCs ends at once with result 0 and writes no configuration.
// R12 - Download with differing CRCs writes sub-indices 1 to 127 and aborts on any missing or wrongly sized block.
// R13 - A successful download commits the configuration by writing the save signature to the store object.
// R14 - The block size used for download equals the one used for upload.
// R15 - Upload and download work only while the module is network master.
// R16 - All data moves over record read and record write transfers.
// R17 - A request while busy is ignored and each operation yields exactly one result code.
`ifndef CBRS_CONSTS_SVH
`define CBRS_CONSTS_SVH

// configuration object and its sub-index range
`define CBRS_CFG_OBJ 16'h1F22
`define CBRS_SUB_FIRST 8'h01
`define CBRS_SUB_LAST 8'h7F
// module CRC location
`define CBRS_CRC_OBJ 16'h1F23
`define CBRS_CRC_SUB 16'h0000
// store-parameters object and save signature
`define CBRS_STORE_OBJ 16'h1010
`define CBRS_STORE_SUB 16'h0001
`define CBRS_SAVE_SIG 32'h65766173
// block size range and storage layout
`define CBRS_SIZE_MIN 16'h0106
`define CBRS_SIZE_MAX 16'hC350
`define CBRS_CRC_OFS 16'h0000
`define CBRS_DATA_OFS 16'h0004
`define CBRS_WORD_BYTES 17'h00004
`define CBRS_LAST_BLK 2'h3
// result codes
`define CBRS_RC_OK 16'h0000
`define CBRS_RC_NOT_MASTER 16'h8001
`define CBRS_RC_NO_BLOCK 16'h8002
`define CBRS_RC_REC_ERR 16'h8003
`define CBRS_RC_OVERFLOW 16'h8004
`define CBRS_RC_BAD_SIZE 16'h8005

`endif

// [rtl/cbrs_pkg.sv]
// types of the configuration backup and restore sequencer
package cbrs_pkg;

    // one transfer request: record (sel=index, addr=sub) or storage (sel=block, addr=byte)
    typedef struct packed {
        logic wr;
        logic [15:0] sel;
        logic [15:0] addr;
        logic [31:0] data;
    } cbrs_xfer_t;

    // answer: err also flags a missing storage block, size is the block size
    typedef struct packed {
        logic err;
        logic [15:0] size;
        logic [31:0] data;
    } cbrs_resp_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HDR = 3'b001,
        S_CRC = 3'b010,
        S_GET = 3'b011,
        S_PUT = 3'b100,
        S_SAVE = 3'b101,
        S_WCRC = 3'b110
    } cbrs_state_t;

endpackage

// [rtl/cbrs_xfer.sv]
// one outstanding transfer towards the record port or the storage port
`timescale 1ns/100ps
module cbrs_xfer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // sequencer side
    input wire logic i_go,
    input wire cbrs_pkg::cbrs_xfer_t i_cmd,
    output logic o_done,
    output cbrs_pkg::cbrs_resp_t o_resp,
    // transfer side
    output logic o_req_valid,
    output cbrs_pkg::cbrs_xfer_t o_req,
    input wire logic i_resp_valid,
    input wire cbrs_pkg::cbrs_resp_t i_resp
);

    // request stays up until answered; the sequencer never issues a second one early
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_req_valid <= 1'b0;
            o_req <= '0;
        end else if (i_go) begin
            o_req_valid <= 1'b1;
            o_req <= i_cmd;
        end else if (i_resp_valid) begin
            o_req_valid <= 1'b0;
        end
    end

    // answer is registered so the sequencer sees stable data with the done pulse
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_done <= 1'b0;
            o_resp <= '0;
        end else begin
            o_done <= o_req_valid & i_resp_valid;
            if (o_req_valid & i_resp_valid) begin
                o_resp <= i_resp;
            end
        end
    end

endmodule // cbrs_xfer

// [rtl/cbrs_seq.sv]
// configuration backup and restore sequencer
`timescale 1ns/100ps
`include "cbrs_consts.svh"
module cbrs_seq (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // request from the controller program
    input wire logic i_req,
    input wire logic i_upload,
    input wire logic i_master_mode,
    input wire logic [15:0] i_first_store_block,
    input wire logic [15:0] i_store_block_size,
    // status
    output logic o_busy,
    output logic o_result_valid,
    output logic [15:0] o_result_code,
    // record read / record write port towards the module
    output logic o_rec_valid,
    output cbrs_pkg::cbrs_xfer_t o_rec,
    input wire logic i_rec_valid,
    input wire cbrs_pkg::cbrs_resp_t i_rec,
    // storage block port
    output logic o_st_valid,
    output cbrs_pkg::cbrs_xfer_t o_st,
    input wire logic i_st_valid,
    input wire cbrs_pkg::cbrs_resp_t i_st
);

    cbrs_pkg::cbrs_state_t state;
    cbrs_pkg::cbrs_state_t next_state;
    logic req_q;
    logic req_rise;
    logic dir_up;
    logic fresh;
    logic [15:0] first_blk;
    logic [15:0] blk_size;
    logic [31:0] stored_crc;
    logic [31:0] mod_crc;
    logic [1:0] cur_n;
    logic [15:0] cur_off;
    logic [7:0] sub;
    logic [15:0] pend;
    logic [15:0] next_pend;
    logic rec_go, st_go, rec_done, st_done;
    cbrs_pkg::cbrs_xfer_t rec_cmd, st_cmd;
    cbrs_pkg::cbrs_resp_t rec_resp, st_resp;
    logic fin, fail, adv, restart, do_get;
    logic [15:0] fin_code, fail_code;
    logic size_bad, hdr_ok, wrap, ovf;
    logic [16:0] nxt_off;
    logic [1:0] g_n;
    logic [15:0] g_off;
    logic [7:0] g_sub;

    function automatic cbrs_pkg::cbrs_xfer_t mk(input logic wr, input logic [15:0] sel,
                                                input logic [15:0] addr, input logic [31:0] data);
        mk = '{wr: wr, sel: sel, addr: addr, data: data};
    endfunction

    // R1 strobe edge detect
    assign req_rise = i_req & ~req_q;
    // R5 block size range
    assign size_bad = (i_store_block_size < `CBRS_SIZE_MIN) || (i_store_block_size > `CBRS_SIZE_MAX);
    // R14 block size must match
    assign hdr_ok = !st_resp.err && (st_resp.size == blk_size);
    // R2 busy while running
    assign o_busy = (state != cbrs_pkg::S_IDLE);

    // R4 next word position, spilling into the next of four blocks
    assign nxt_off = {1'b0, cur_off} + `CBRS_WORD_BYTES;
    assign wrap = (nxt_off + `CBRS_WORD_BYTES) > {1'b0, blk_size};
    assign ovf = wrap && (cur_n == `CBRS_LAST_BLK);
    assign g_n = restart ? 2'h0 : (wrap ? cur_n + 2'h1 : cur_n);
    assign g_off = restart ? `CBRS_DATA_OFS : (wrap ? 16'h0000 : nxt_off[15:0]);
    assign g_sub = restart ? `CBRS_SUB_FIRST : sub + 8'h01;

    // sequencing decisions; transfers are launched on the transition into a wait state
    always_comb begin
        next_state = state;
        rec_go = 1'b0;
        st_go = 1'b0;
        rec_cmd = '0;
        st_cmd = '0;
        fin = 1'b0;
        fin_code = pend;
        next_pend = pend;
        fail = 1'b0;
        fail_code = `CBRS_RC_OK;
        adv = 1'b0;
        restart = 1'b0;
        do_get = 1'b0;
        unique case (state)
            cbrs_pkg::S_IDLE: begin
                // R17 requests only taken while idle
                if (req_rise) begin
                    // R15 master mode only
                    if (!i_master_mode) begin
                        fin = 1'b1;
                        fin_code = `CBRS_RC_NOT_MASTER;
                    end else if (size_bad) begin
                        fin = 1'b1;
                        fin_code = `CBRS_RC_BAD_SIZE;
                    end else begin
                        st_go = 1'b1;
                        st_cmd = mk(1'b0, i_first_store_block, `CBRS_CRC_OFS, 32'h00000000);
                        next_state = cbrs_pkg::S_HDR;
                    end
                end
            end
            cbrs_pkg::S_HDR: begin
                if (st_done) begin
                    // R6 fresh upload when first block unusable
                    // R10 download needs a usable first block
                    if (hdr_ok || dir_up) begin
                        rec_go = 1'b1;
                        rec_cmd = mk(1'b0, `CBRS_CRC_OBJ, `CBRS_CRC_SUB, 32'h00000000);
                        next_state = cbrs_pkg::S_CRC;
                    end else begin
                        fin = 1'b1;
                        fin_code = `CBRS_RC_NO_BLOCK;
                        next_state = cbrs_pkg::S_IDLE;
                    end
                end
            end
            cbrs_pkg::S_CRC: begin
                if (rec_done) begin
                    // R7 R11 equal CRC ends the operation
                    if (rec_resp.err) begin
                        fail = 1'b1;
                        fail_code = `CBRS_RC_REC_ERR;
                    end else if (!fresh && rec_resp.data == stored_crc) begin
                        fin = 1'b1;
                        fin_code = `CBRS_RC_OK;
                        next_state = cbrs_pkg::S_IDLE;
                    end else begin
                        restart = 1'b1;
                        do_get = 1'b1;
                    end
                end
            end
            cbrs_pkg::S_GET: begin
                if (dir_up ? rec_done : st_done) begin
                    // R12 every block checked for presence and size
                    if (dir_up ? rec_resp.err : !hdr_ok) begin
                        fail = 1'b1;
                        fail_code = dir_up ? `CBRS_RC_REC_ERR : `CBRS_RC_NO_BLOCK;
                    end else if (dir_up) begin
                        st_go = 1'b1;
                        st_cmd = mk(1'b1, first_blk + {14'h0000, cur_n}, cur_off, rec_resp.data);
                        next_state = cbrs_pkg::S_PUT;
                    end else begin
                        rec_go = 1'b1;
                        rec_cmd = mk(1'b1, `CBRS_CFG_OBJ, {8'h00, sub}, st_resp.data);
                        next_state = cbrs_pkg::S_PUT;
                    end
                end
            end
            cbrs_pkg::S_PUT: begin
                if (dir_up ? st_done : rec_done) begin
                    if (dir_up ? st_resp.err : rec_resp.err) begin
                        fail = 1'b1;
                        fail_code = dir_up ? `CBRS_RC_NO_BLOCK : `CBRS_RC_REC_ERR;
                    end else if (sub == `CBRS_SUB_LAST) begin
                        if (dir_up) begin
                            // upload finishes by storing the new CRC
                            st_go = 1'b1;
                            st_cmd = mk(1'b1, first_blk, `CBRS_CRC_OFS, mod_crc);
                            next_pend = `CBRS_RC_OK;
                            next_state = cbrs_pkg::S_WCRC;
                        end else begin
                            // R13 commit with the save signature
                            rec_go = 1'b1;
                            rec_cmd = mk(1'b1, `CBRS_STORE_OBJ, `CBRS_STORE_SUB, `CBRS_SAVE_SIG);
                            next_state = cbrs_pkg::S_SAVE;
                        end
                    end else if (ovf) begin
                        fail = 1'b1;
                        fail_code = `CBRS_RC_OVERFLOW;
                    end else begin
                        adv = 1'b1;
                        do_get = 1'b1;
                    end
                end
            end
            cbrs_pkg::S_SAVE: begin
                if (rec_done) begin
                    fin = 1'b1;
                    fin_code = rec_resp.err ? `CBRS_RC_REC_ERR : `CBRS_RC_OK;
                    next_state = cbrs_pkg::S_IDLE;
                end
            end
            cbrs_pkg::S_WCRC: begin
                if (st_done) begin
                    fin = 1'b1;
                    next_state = cbrs_pkg::S_IDLE;
                end
            end
            default: next_state = cbrs_pkg::S_IDLE;
        endcase
        // R8 R12 fetch one configuration word
        if (do_get) begin
            next_state = cbrs_pkg::S_GET;
            if (dir_up) begin
                rec_go = 1'b1;
                rec_cmd = mk(1'b0, `CBRS_CFG_OBJ, {8'h00, g_sub}, 32'h00000000);
            end else begin
                st_go = 1'b1;
                st_cmd = mk(1'b0, first_blk + {14'h0000, g_n}, g_off, 32'h00000000);
            end
        end
        // R9 an upload error clears the stored CRC before reporting
        if (fail) begin
            next_pend = fail_code;
            if (dir_up) begin
                st_go = 1'b1;
                st_cmd = mk(1'b1, first_blk, `CBRS_CRC_OFS, 32'h00000000);
                next_state = cbrs_pkg::S_WCRC;
            end else begin
                fin = 1'b1;
                fin_code = fail_code;
                next_state = cbrs_pkg::S_IDLE;
            end
        end
    end

    // state and strobe history
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= cbrs_pkg::S_IDLE;
            req_q <= 1'b0;
            pend <= `CBRS_RC_OK;
        end else begin
            state <= next_state;
            req_q <= i_req;
            pend <= next_pend;
        end
    end

    // operation parameters latched at start; later changes are ignored
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            dir_up <= 1'b0;
            first_blk <= 16'h0000;
            blk_size <= 16'h0000;
        end else if (state == cbrs_pkg::S_IDLE && req_rise) begin
            dir_up <= i_upload;
            first_blk <= i_first_store_block;
            blk_size <= i_store_block_size;
        end
    end

    // CRCs and fresh-upload flag
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fresh <= 1'b0;
            stored_crc <= 32'h00000000;
            mod_crc <= 32'h00000000;
        end else begin
            if (state == cbrs_pkg::S_HDR && st_done) begin
                fresh <= !hdr_ok;
                stored_crc <= st_resp.data;
            end
            if (state == cbrs_pkg::S_CRC && rec_done) begin
                mod_crc <= rec_resp.data;
            end
        end
    end

    // word position walk
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cur_n <= 2'h0;
            cur_off <= `CBRS_DATA_OFS;
            sub <= `CBRS_SUB_FIRST;
        end else if (restart || adv) begin
            cur_n <= g_n;
            cur_off <= g_off;
            sub <= g_sub;
        end
    end

    // R3 result held until the next accepted strobe; fin wins over the clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_result_valid <= 1'b0;
            o_result_code <= `CBRS_RC_OK;
        end else if (fin) begin
            o_result_valid <= 1'b1;
            o_result_code <= fin_code;
        end else if (state == cbrs_pkg::S_IDLE && req_rise) begin
            o_result_valid <= 1'b0;
        end
    end

    // R16 record port carries every module access
    cbrs_xfer u_rec (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_go(rec_go),
        .i_cmd(rec_cmd),
        .o_done(rec_done),
        .o_resp(rec_resp),
        .o_req_valid(o_rec_valid),
        .o_req(o_rec),
        .i_resp_valid(i_rec_valid),
        .i_resp(i_rec)
    );

    cbrs_xfer u_st (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_go(st_go),
        .i_cmd(st_cmd),
        .o_done(st_done),
        .o_resp(st_resp),
        .o_req_valid(o_st_valid),
        .o_req(o_st),
        .i_resp_valid(i_st_valid),
        .i_resp(i_st)
    );

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_crc_equal;
        state == cbrs_pkg::S_CRC && rec_done && !rec_resp.err && !fresh && rec_resp.data == stored_crc;
    endsequence
    sequence s_hdr_bad_dl;
        state == cbrs_pkg::S_HDR && st_done && !dir_up && !hdr_ok;
    endsequence

    a_busy_until_done: assert property (o_busy && !fin |=> o_busy) // R2
        else $error("busy fell before completion");
    a_result_on_fall: assert property ($fell(o_busy) |-> o_result_valid) // R3
        else $error("no result when busy fell");
    a_result_holds: assert property (o_result_valid && !req_rise |=> o_result_valid && $stable(o_result_code)) // R3
        else $error("result changed without strobe");
    a_one_result: assert property (fin |=> !fin) // R17
        else $error("two results for one operation");
    a_busy_ignores_req: assert property (o_busy && req_rise && !fin |=> $stable(first_blk) && // R17
        $stable(dir_up) && (state != cbrs_pkg::S_HDR || $past(state) == cbrs_pkg::S_HDR))
        else $error("request taken while busy");
    a_master_gate: assert property (state == cbrs_pkg::S_IDLE && req_rise && !i_master_mode |=> !o_busy ##0 o_result_code == `CBRS_RC_NOT_MASTER) // R15
        else $error("operation started outside master mode");
    a_crc_match_stop: assert property (s_crc_equal |=> !o_busy && o_result_valid && o_result_code == `CBRS_RC_OK) // R7
        else $error("equal CRC did not stop with result 0");
    a_dl_no_block: assert property (s_hdr_bad_dl |=> !o_busy && o_result_code == `CBRS_RC_NO_BLOCK) // R10
        else $error("bad first block not reported");
    a_cfg_sub_range: assert property (o_rec_valid && o_rec.sel == `CBRS_CFG_OBJ |-> o_rec.addr >= 16'h0001 && o_rec.addr <= 16'h007F) // R8
        else $error("configuration sub-index out of range");
    a_save_commit: assert property (state == cbrs_pkg::S_SAVE |-> o_rec.wr && o_rec.sel == `CBRS_STORE_OBJ && o_rec.data == `CBRS_SAVE_SIG) // R13
        else $error("commit write malformed");
    a_crc_clear: assert property (state == cbrs_pkg::S_WCRC && pend != `CBRS_RC_OK |-> o_st.wr && o_st.addr == `CBRS_CRC_OFS && o_st.data == 32'h00000000) // R9
        else $error("stored CRC not cleared on error");
    a_block_limit: assert property (o_st_valid |-> o_st.sel - first_blk <= 16'h0003) // R4
        else $error("storage access beyond four blocks");

endmodule // cbrs_seq

// [testbench/cbrs_far_model.sv]
// far-side model: controller storage blocks and the module's record objects
`timescale 1ns/100ps
`include "cbrs_consts.svh"
module cbrs_far_model (
    // clock and bench controls
    input wire logic i_clk,
    input wire logic [3:0] i_slow,
    input wire logic [15:0] i_blk_size,
    input wire logic [15:0] i_fail_sub,
    // storage block port
    input wire logic i_st_req,
    input wire cbrs_pkg::cbrs_xfer_t i_st,
    output logic o_st_ack,
    output cbrs_pkg::cbrs_resp_t o_st,
    // record port
    input wire logic i_rec_req,
    input wire cbrs_pkg::cbrs_xfer_t i_rec,
    output logic o_rec_ack,
    output cbrs_pkg::cbrs_resp_t o_rec
);
    logic [31:0] st_mem [logic [31:0]];
    bit present [logic [15:0]];
    logic [31:0] cfg [128];
    logic [31:0] crc;
    logic [31:0] save_val;
    int cfg_rd = 0;
    int cfg_wr = 0;
    int save_wr = 0;
    logic [3:0] st_wait = 4'h0;
    logic [3:0] rec_wait = 4'h0;

    initial begin
        o_st_ack = 1'b0;
        o_rec_ack = 1'b0;
        o_st = '0;
        o_rec = '0;
    end

    // storage answers; a block exists once written, always of the agreed size
    always @(posedge i_clk) begin
        o_st_ack <= 1'b0;
        o_st <= ~o_st; // released answer lines wander so stale data is never trusted
        if (i_st_req && !o_st_ack) begin
            if (st_wait < i_slow) begin
                st_wait <= st_wait + 4'h1;
            end else begin
                st_wait <= 4'h0;
                o_st_ack <= 1'b1;
                o_st.size <= i_blk_size;
                o_st.err <= !present.exists(i_st.sel) && !i_st.wr;
                o_st.data <= st_mem.exists({i_st.sel, i_st.addr}) ?
                             st_mem[{i_st.sel, i_st.addr}] : 32'h00000000;
                if (i_st.wr) begin
                    present[i_st.sel] = 1'b1;
                    st_mem[{i_st.sel, i_st.addr}] = i_st.data;
                end
            end
        end
    end

    // record answers: module CRC, configuration object, store object
    always @(posedge i_clk) begin
        o_rec_ack <= 1'b0;
        o_rec <= ~o_rec;
        if (i_rec_req && !o_rec_ack) begin
            if (rec_wait < i_slow) begin
                rec_wait <= rec_wait + 4'h1;
            end else begin
                rec_wait <= 4'h0;
                o_rec_ack <= 1'b1;
                o_rec.err <= 1'b0;
                o_rec.data <= (i_rec.sel == `CBRS_CRC_OBJ) ? crc : cfg[i_rec.addr[6:0]];
                if (i_rec.sel == `CBRS_CFG_OBJ && i_rec.addr == i_fail_sub) begin
                    o_rec.err <= 1'b1;
                end else if (i_rec.sel == `CBRS_CFG_OBJ && i_rec.wr) begin
                    cfg[i_rec.addr[6:0]] = i_rec.data;
                    cfg_wr++;
                end else if (i_rec.sel == `CBRS_CFG_OBJ) begin
                    cfg_rd++;
                end else if (i_rec.sel == `CBRS_STORE_OBJ && i_rec.wr) begin
                    save_wr++;
                    save_val = i_rec.data;
                end
            end
        end
    end
endmodule // cbrs_far_model

// [testbench/cbrs_seq_bench.sv]
// self-checking bench for the configuration backup and restore sequencer
`timescale 1ns/100ps
`include "cbrs_consts.svh"
module cbrs_seq_bench;
    logic i_clk, i_sys_rst, i_req, i_upload, i_master_mode;
    logic [15:0] i_first_store_block, i_store_block_size, fail_sub, blk;
    logic o_busy, o_result_valid, o_rec_valid, i_rec_valid, o_st_valid, i_st_valid;
    logic [15:0] o_result_code;
    cbrs_pkg::cbrs_xfer_t o_rec, o_st;
    cbrs_pkg::cbrs_resp_t i_rec, i_st;
    logic [3:0] slow;
    logic [31:0] seed, busy_seen, rd0;
    logic [31:0] golden [128];
    int error_cnt = 0;
    int num_checks = 0;

    // clock: 4 ns period
    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;

    cbrs_seq u_dut (.i_clk, .i_sys_rst, .i_req, .i_upload, .i_master_mode,
        .i_first_store_block, .i_store_block_size, .o_busy, .o_result_valid,
        .o_result_code, .o_rec_valid, .o_rec, .i_rec_valid, .i_rec,
        .o_st_valid, .o_st, .i_st_valid, .i_st);

    cbrs_far_model u_far (.i_clk(i_clk), .i_slow(slow), .i_blk_size(i_store_block_size),
        .i_fail_sub(fail_sub), .i_st_req(o_st_valid), .i_st(o_st), .o_st_ack(i_st_valid),
        .o_st(i_st), .i_rec_req(o_rec_valid), .i_rec(o_rec), .o_rec_ack(i_rec_valid),
        .o_rec(i_rec));

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected code at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one operation; poke re-strobes while busy, which must be ignored
    task automatic run_op(input string name, input logic up, input logic mst,
                          input logic [15:0] size, input logic poke);
        int n;
        @(negedge i_clk);
        i_upload = up;
        i_master_mode = mst;
        i_first_store_block = blk;
        i_store_block_size = size;
        slow = 4'(xorshift() & 32'h3);
        i_req = 1'b1;
        busy_seen = 32'h0;
        repeat (3) begin
            @(negedge i_clk);
            busy_seen |= {31'h0, o_busy};
        end
        n = 0;
        while ((o_busy !== 1'b0 || o_result_valid !== 1'b1) && n < 20000) begin
            @(negedge i_clk);
            busy_seen |= {31'h0, o_busy};
            n++;
            if (poke && n == 40) i_req = 1'b0;
            if (poke && n == 41) i_req = 1'b1;
        end
        if (n >= 20000) begin
            error_cnt++;
            $display("unexpected hang at %0t: busy %h valid %h", $time, o_busy, o_result_valid);
            tally_and_finish();
        end
        // holding the strobe high after a refused edge must not retrigger
        repeat (poke ? 4 : 0) begin
            @(negedge i_clk);
            chk_word({31'h0, o_busy}, 32'h0);
        end
        i_req = 1'b0;
        @(negedge i_clk);
        $display("test %0s done", name);
    endtask

    // main sequence
    initial begin
        seed = 32'h00000040;
        i_sys_rst = 1'b1;
        i_req = 1'b0;
        i_upload = 1'b0;
        i_master_mode = 1'b0;
        i_first_store_block = 16'h0000;
        i_store_block_size = 16'h0000;
        fail_sub = 16'hFFFF;
        slow = 4'h0;
        blk = 16'h0010 + 16'(xorshift() & 32'hFF);
        u_far.crc = xorshift();
        for (int i = 0; i < 128; i++) u_far.cfg[i] = xorshift();
        repeat (16) @(negedge i_clk);
        i_sys_rst = 1'b0;
        run_op("not_master", 1'b1, 1'b0, 16'h0106, 1'b0);
        chk_code(o_result_code, `CBRS_RC_NOT_MASTER);
        chk_word(busy_seen, 32'h0);
        run_op("size_low", 1'b1, 1'b1, 16'h0105, 1'b0);
        chk_code(o_result_code, `CBRS_RC_BAD_SIZE);
        run_op("size_high", 1'b0, 1'b1, 16'hC351, 1'b0);
        chk_code(o_result_code, `CBRS_RC_BAD_SIZE);
        run_op("fresh_upload", 1'b1, 1'b1, 16'h0106, 1'b0);
        chk_code(o_result_code, `CBRS_RC_OK);
        chk_word(busy_seen, 32'h1);
        chk_word(u_far.st_mem[{blk, 16'h0000}], u_far.crc);
        chk_word(32'(u_far.cfg_rd), 32'h0000007F);
        chk_word(32'(u_far.present.exists(16'(blk + 16'h1))), 32'h1);
        chk_word(32'(u_far.present.exists(16'(blk + 16'h4))), 32'h0);
        rd0 = 32'(u_far.cfg_rd);
        run_op("upload_same_crc", 1'b1, 1'b1, 16'h0106, 1'b0);
        chk_code(o_result_code, `CBRS_RC_OK);
        chk_word(32'(u_far.cfg_rd), rd0);
        run_op("download_same_crc", 1'b0, 1'b1, 16'h0106, 1'b0);
        chk_code(o_result_code, `CBRS_RC_OK);
        chk_word(32'(u_far.cfg_wr + u_far.save_wr), 32'h0);
        u_far.crc = u_far.crc ^ 32'h00000001;
        fail_sub = 16'h0009;
        run_op("upload_error", 1'b1, 1'b1, 16'h0106, 1'b0);
        chk_code(o_result_code, `CBRS_RC_REC_ERR);
        chk_word(u_far.st_mem[{blk, 16'h0000}], 32'h00000000);
        fail_sub = 16'hFFFF;
        run_op("upload_retry", 1'b1, 1'b1, 16'h0106, 1'b1);
        chk_code(o_result_code, `CBRS_RC_OK);
        chk_word(u_far.st_mem[{blk, 16'h0000}], u_far.crc);
        // replace the module's configuration, then restore it
        for (int i = 1; i < 128; i++) begin
            golden[i] = u_far.cfg[i];
            u_far.cfg[i] = xorshift();
        end
        u_far.crc = ~u_far.crc;
        run_op("download_restore", 1'b0, 1'b1, 16'h0106, 1'b0);
        chk_code(o_result_code, `CBRS_RC_OK);
        for (int i = 1; i < 128; i++) begin
            chk_word(u_far.cfg[i], golden[i]);
        end
        chk_word(u_far.save_val, `CBRS_SAVE_SIG);
        chk_word(32'(u_far.save_wr), 32'h1);
        blk = blk + 16'h0040;
        run_op("download_missing", 1'b0, 1'b1, 16'h0106, 1'b0);
        chk_code(o_result_code, `CBRS_RC_NO_BLOCK);
        tally_and_finish();
    end
endmodule // cbrs_seq_bench
